/* File: dv/cwd_config_word_decode_asserts.sv */
// Checker for the configuration word decoder, bound to its top module.
// Assumes configuration words only change while reset is held.
`timescale 1ns/1ps
module cwd_asserts (
	// Clock and reset
	input wire logic        clock_in,
	input wire logic        rst_in,
	// Configuration words and events
	input wire logic [13:0] cfg_word1_in,
	input wire logic [13:0] cfg_word2_in,
	input wire logic [13:0] cfg_word4_in,
	input wire logic        stack_fault_in,
	input wire logic        sleep_in,
	input wire logic        master_clear_pin_in,
	// Bus response and decoded controls
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	input wire logic        fail_safe_monitor_enable_out,
	input wire logic [2:0]  current_oscillator_select_out,
	input wire logic        second_oscillator_pin_out,
	input wire logic        second_oscillator_pin_oe_out,
	input wire logic        debugger_enable_out,
	input wire logic        stack_fault_reset_out,
	input wire logic        zero_cross_enable_out,
	input wire logic        brownout_low_trip_out,
	input wire logic        brownout_enable_out,
	input wire logic        low_power_brownout_enable_out,
	input wire logic        master_clear_reset_out,
	input wire logic        master_clear_port_mode_out
);
	// ==========================================================
	// Helper: high once words have been captured
	logic live_reg;
	logic mclr_en;
	assign mclr_en = cfg_word4_in[13] | cfg_word2_in[0];
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) live_reg <= 1'b0;
		else live_reg <= 1'b1;
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// Assertions
	chk_fail_safe: assert property (live_reg |-> fail_safe_monitor_enable_out == cfg_word1_in[13])
		else $error("fail-safe enable differs from word 1");
	chk_clk_out_pin: assert property (live_reg |-> second_oscillator_pin_oe_out ==
		(cfg_word1_in[2] && !cfg_word1_in[8]) && (second_oscillator_pin_oe_out || !second_oscillator_pin_out))
		else $error("clock-out pin enable wrong");
	chk_clk_quarter: assert property (live_reg && $past(live_reg, 4) &&
		second_oscillator_pin_oe_out |->
		second_oscillator_pin_out == $past(second_oscillator_pin_out, 4) &&
		second_oscillator_pin_out != $past(second_oscillator_pin_out, 2))
		else $error("clock-out pin does not run at a quarter of the clock");
	chk_reset_osc: assert property ($rose(live_reg) |->
		current_oscillator_select_out == cfg_word1_in[6:4])
		else $error("current oscillator not loaded from word 1");
	chk_debug_inv: assert property (live_reg |-> debugger_enable_out == !cfg_word2_in[13])
		else $error("debugger enable not inverse of bit");
	chk_stack_reset: assert property (live_reg && stack_fault_in |=>
		stack_fault_reset_out == cfg_word2_in[12])
		else $error("stack fault reset wrong");
	chk_zero_cross: assert property (live_reg && !cfg_word2_in[10] |-> zero_cross_enable_out)
		else $error("zero-cross detector not forced on");
	chk_bor_trip: assert property (live_reg |-> brownout_low_trip_out == cfg_word2_in[9] &&
		low_power_brownout_enable_out == !cfg_word2_in[5])
		else $error("brown-out trip or low-power enable wrong");
	chk_bor_enable: assert property (live_reg && cfg_word2_in[7:6] != 2'h1 |->
		brownout_enable_out == (cfg_word2_in[7] && (cfg_word2_in[6] || !sleep_in)))
		else $error("brown-out enable wrong");
	chk_mclr_pin: assert property (live_reg && mclr_en && $fell(master_clear_pin_in) |->
		##[1:3] master_clear_reset_out)
		else $error("master clear pin did not reset");
	chk_mclr_mode: assert property (live_reg |-> master_clear_port_mode_out == !mclr_en)
		else $error("master clear port mode wrong");
	chk_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus response not ready and okay");
	// ==========================================================
	// Coverage
	cov_stack: cover property (live_reg && stack_fault_in && cfg_word2_in[12]);
	cov_clk_out: cover property (live_reg && second_oscillator_pin_oe_out);
	cov_mclr: cover property (master_clear_reset_out);
endmodule : cwd_asserts

bind cwd_config_word_decode cwd_asserts chk_u (
	.clock_in(clock_in), .rst_in(rst_in), .cfg_word1_in(cfg_word1_in),
	.cfg_word2_in(cfg_word2_in), .cfg_word4_in(cfg_word4_in), .stack_fault_in(stack_fault_in),
	.sleep_in(sleep_in), .master_clear_pin_in(master_clear_pin_in),
	.hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
	.fail_safe_monitor_enable_out(fail_safe_monitor_enable_out),
	.current_oscillator_select_out(current_oscillator_select_out),
	.second_oscillator_pin_out(second_oscillator_pin_out),
	.second_oscillator_pin_oe_out(second_oscillator_pin_oe_out),
	.debugger_enable_out(debugger_enable_out), .stack_fault_reset_out(stack_fault_reset_out),
	.zero_cross_enable_out(zero_cross_enable_out), .brownout_low_trip_out(brownout_low_trip_out),
	.brownout_enable_out(brownout_enable_out),
	.low_power_brownout_enable_out(low_power_brownout_enable_out),
	.master_clear_reset_out(master_clear_reset_out),
	.master_clear_port_mode_out(master_clear_port_mode_out));

/* File: dv/cwd_config_word_decode_tb.sv */
// Self-checking bench for the configuration word decoder.
// Assumes zero-wait bus answers are handled by waiting on hreadyout.
`timescale 1ns/1ps
module cwd_config_word_decode_tb;
	localparam int LIMIT = 20000;
	logic        clk, rst, hwr, sf, sl, pin, rd_flag;
	logic [13:0] w [5];
	logic [13:0] t;
	logic [31:0] ha, hwd, hrd;
	logic [1:0]  htr;
	logic        hro, hrs, fsm, oe, po, dbg, sfr, lck, zce, ltr, bor, lpb, done, mcr, mpm;
	logic [2:0]  cur, frq, ext;
	logic [3:0]  div;
	logic [31:0] exp_q [$];
	int          mismatches, samples_checked, cycles, seed, tgt;

	cwd_config_word_decode #(.PWRT_LONG_CYCLES(40), .PWRT_MID_CYCLES(20),
		.PWRT_SHORT_CYCLES(10)) dut_u (
		.clock_in(clk), .rst_in(rst), .cfg_word1_in(w[0]), .cfg_word2_in(w[1]),
		.cfg_word3_in(w[2]), .cfg_word4_in(w[3]), .cfg_word5_in(w[4]), .hsel_in(1'b1),
		.haddr_in(ha), .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hready_in(hro),
		.hwdata_in(hwd), .hrdata_out(hrd), .hreadyout_out(hro), .hresp_out(hrs),
		.stack_fault_in(sf), .sleep_in(sl), .master_clear_pin_in(pin),
		.fail_safe_monitor_enable_out(fsm), .current_oscillator_select_out(cur),
		.internal_frequency_select_out(frq), .clock_divider_field_out(div),
		.external_oscillator_mode_out(ext), .second_oscillator_pin_out(po),
		.second_oscillator_pin_oe_out(oe), .debugger_enable_out(dbg),
		.stack_fault_reset_out(sfr), .pin_select_lock_flag_out(lck),
		.zero_cross_enable_out(zce), .brownout_low_trip_out(ltr), .brownout_enable_out(bor),
		.low_power_brownout_enable_out(lpb), .power_up_done_out(done),
		.master_clear_reset_out(mcr), .master_clear_port_mode_out(mpm));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ==========================================================
	// Comparison and report
	task automatic check_pin(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_pin
	task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
		check_pin(got, exp);
	endtask : check_rd
	task automatic wrap_up();
		$display("Mismatches %0d, comparisons %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cycles++;
		if (rd_flag && hro === 1'b1) check_rd(hrd, exp_q.pop_front());
		if (cycles > LIMIT) begin
			mismatches++;
			wrap_up();
		end
	end
	// ==========================================================
	// Bus master, entered just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		htr <= cwd_pkg::HTRANS_NONSEQ;
		ha <= a;
		hwr <= wr;
		@(posedge clk);
		while (hro !== 1'b1) @(posedge clk);
		htr <= 2'h0;
		hwd <= d;
		rd_flag <= !wr;
		@(posedge clk);
		while (hro !== 1'b1) @(posedge clk);
		rd_flag <= 1'b0;
	endtask : bus
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	function automatic logic [31:0] adr(input logic [15:0] idx);
		return {14'h0000, idx, 2'h0};
	endfunction : adr
	task automatic lock_seq(input logic v);
		bus(1'b1, adr(cwd_pkg::IDX_UNLOCK), {24'h00_0000, cwd_pkg::UNLOCK_KEY1});
		bus(1'b1, adr(cwd_pkg::IDX_UNLOCK), {24'h00_0000, cwd_pkg::UNLOCK_KEY2});
		bus(1'b1, adr(cwd_pkg::IDX_PIN_LOCK), {31'h0000_0000, v});
	endtask : lock_seq
	function automatic logic [6:0] fd(input logic [2:0] c);
		case (c)
			cwd_pkg::RST_FAST_1MHZ: return {cwd_pkg::FRQ_4MHZ, cwd_pkg::DIV_BY4};
			cwd_pkg::RST_FAST_PLL2: return {cwd_pkg::FRQ_16MHZ, cwd_pkg::DIV_BY1};
			cwd_pkg::RST_FAST_32: return {cwd_pkg::FRQ_32MHZ, cwd_pkg::DIV_BY1};
			default: return {cwd_pkg::FRQ_4MHZ, cwd_pkg::DIV_BY1};
		endcase
	endfunction : fd
	// ==========================================================
	// Main sequence
	initial begin
		seed = 42442;
		{rst, hwr, sf, sl, pin, rd_flag} = 6'b100010;
		{ha, hwd, htr} = '0;
		for (int k = 0; k < 5; k++) w[k] = 14'h3fff;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			rst <= 1'b1;
			for (int k = 0; k < 5; k++) begin
				t = 14'($random(seed));
				if (k == 0) begin
					t[6:4] = i[2:0];
					t[2:0] = (i[2:0] == 3'h3) ? 3'h4 : i[2:0];
				end
				w[k] <= t;
			end
			sl <= 1'($random(seed));
			repeat (10) @(posedge clk);
			rst <= 1'b0;
			tgt = (w[1][2:1] == 2'h3) ? 0 : (w[1][2:1] == 2'h2) ? 40 : (w[1][2:1] == 2'h1) ? 20 : 10;
			for (int c = 1; c <= tgt + 6; c++) begin
				@(negedge clk);
				if (c == tgt - 3) check_pin({31'h0, done}, 32'h0000_0000);
			end
			check_pin({31'h0, done}, 32'h0000_0001);
			check_pin({29'h0, cur}, {29'h0, w[0][6:4]});
			check_pin({25'h0, frq, div}, {25'h0, fd(w[0][6:4])});
			check_pin({29'h0, ext}, {29'h0, w[0][2:0]});
			check_pin({29'h0, fsm, ltr, lpb}, {29'h0, w[0][13], w[1][9], !w[1][5]});
			@(posedge clk);
			for (int k = 0; k < 5; k++) begin
				rd(adr(cwd_pkg::IDX_OSC_WORD + 16'(k)), {18'h0_0000, w[k]});
				bus(1'b1, adr(cwd_pkg::IDX_OSC_WORD + 16'(k)), 32'h0000_0000);
				rd(adr(cwd_pkg::IDX_OSC_WORD + 16'(k)), {18'h0_0000, w[k]});
			end
			rd(32'h0002_0060, 32'h0000_0000);
			rd(32'h0002_001e, 32'h0000_0000);
			bus(1'b1, adr(cwd_pkg::IDX_OSC_CTRL), 32'h0000_0053);
			@(posedge clk);
			@(negedge clk);
			check_pin({29'h0, cur}, {29'h0, w[0][11] ? 3'h5 : w[0][6:4]});
			check_pin({28'h0, div}, {28'h0, w[0][11] ? 4'h3 : 4'(fd(w[0][6:4]))});
			@(posedge clk);
			bus(1'b1, adr(cwd_pkg::IDX_PIN_LOCK), 32'h0000_0001);
			lock_seq(1'b1);
			rd(adr(cwd_pkg::IDX_PIN_LOCK), {30'h0, w[1][11], 1'b1});
			lock_seq(1'b0);
			@(negedge clk);
			check_pin({31'h0, lck}, {31'h0, w[1][11]});
			@(posedge clk);
			lock_seq(1'b1);
			@(negedge clk);
			check_pin({31'h0, lck}, 32'h0000_0001);
			for (int s = 0; s < 4; s++) begin
				@(posedge clk);
				bus(1'b1, adr(cwd_pkg::IDX_SW_ENABLE), 32'(s));
				@(negedge clk);
				check_pin({31'h0, zce}, {31'h0, w[1][10] ? s[0] : 1'b1});
				check_pin({31'h0, bor}, {31'h0, (w[1][7:6] == 2'h1) ? s[1] :
					(w[1][7] && (w[1][6] || !sl))});
			end
			@(posedge clk);
			rd(adr(cwd_pkg::IDX_STATUS), {25'h0, 1'b1, w[3][13] | w[1][0],
				w[0][2] & !w[0][8], 1'b1, (w[1][7:6] == 2'h1) || (w[1][7] && (w[1][6] || !sl)),
				w[1][11], 1'b1});
			@(posedge clk);
			sf <= 1'b1;
			@(posedge clk);
			sf <= 1'b0;
			@(negedge clk);
			check_pin({31'h0, sfr}, {31'h0, w[1][12]});
			@(posedge clk);
			pin <= 1'b0;
			repeat (4) @(posedge clk);
			@(negedge clk);
			check_pin({30'h0, mcr, mpm}, {30'h0, w[3][13] | w[1][0], !(w[3][13] | w[1][0])});
			@(posedge clk);
			pin <= 1'b1;
		end
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule : cwd_config_word_decode_tb

/* File: src/cwd_config_word_decode.sv */
// Configuration word decoder: holds five 14-bit words, decodes them into
// static controls and reset defaults, with an AHB-Lite register port.
// Assumes words are stable on cfg_word*_in from reset onward, one clock domain.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cwd_config_word_decode #(
	parameter int PWRT_LONG_CYCLES  = cwd_pkg::PWRT_LONG_MS * (cwd_pkg::CLOCK_HZ / 1000),
	parameter int PWRT_MID_CYCLES   = cwd_pkg::PWRT_MID_MS * (cwd_pkg::CLOCK_HZ / 1000),
	parameter int PWRT_SHORT_CYCLES = cwd_pkg::PWRT_SHORT_MS * (cwd_pkg::CLOCK_HZ / 1000)
) (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// Nonvolatile configuration words
	input  wire logic [13:0] cfg_word1_in,
	input  wire logic [13:0] cfg_word2_in,
	input  wire logic [13:0] cfg_word3_in,
	input  wire logic [13:0] cfg_word4_in,
	input  wire logic [13:0] cfg_word5_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Device events and pins
	input  wire logic        stack_fault_in,
	input  wire logic        sleep_in,
	input  wire logic        master_clear_pin_in,
	// Clock controls
	output logic             fail_safe_monitor_enable_out,
	output logic      [2:0]  current_oscillator_select_out,
	output logic      [2:0]  internal_frequency_select_out,
	output logic      [3:0]  clock_divider_field_out,
	output logic      [2:0]  external_oscillator_mode_out,
	output logic             second_oscillator_pin_out,
	output logic             second_oscillator_pin_oe_out,
	// Supervisor controls
	output logic             debugger_enable_out,
	output logic             stack_fault_reset_out,
	output logic             pin_select_lock_flag_out,
	output logic             zero_cross_enable_out,
	output logic             brownout_low_trip_out,
	output logic             brownout_enable_out,
	output logic             low_power_brownout_enable_out,
	output logic             power_up_done_out,
	output logic             master_clear_reset_out,
	output logic             master_clear_port_mode_out
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [13:0] w1;
		logic [13:0] w2;
		logic [13:0] w3;
		logic [13:0] w4;
		logic [13:0] w5;
		logic        loaded;
		logic [2:0]  cur_osc;
		logic [2:0]  cur_frq;
		logic [3:0]  cur_div;
		logic [2:0]  new_osc;
		logic [3:0]  new_div;
		logic        switch_pend;
		logic [1:0]  unlock_step;
		logic        pin_lock;
		logic        pin_frozen;
		logic        zcd_sw;
		logic        bor_sw;
		logic [1:0]  div4;
		logic        wr_pend;
		logic [15:0] wr_idx;
		logic [31:0] rdata;
		logic [19:0] pwrt_cnt;
		logic        pwrt_done;
		logic [1:0]  mclr_sync;
		logic        stack_rst;
	} cwd_state_t;

	cwd_state_t s_reg;
	cwd_state_t s_next;

	// Top bit of the three-bit external mode field
	localparam int POS_EXT_MODE_HI = cwd_pkg::POS_EXT_MODE + 2;

	logic        addr_ok;
	logic [15:0] addr_idx;
	logic        take;
	logic        clk_out_mode;
	logic        one_way;
	logic        zcd_on;
	logic        bor_on;
	logic        mclr_on;
	logic [31:0] status_word;
	logic [19:0] pwrt_target;
	logic [2:0]  rst_code;

	// ==========================================================
	// Decode of latched words
	always_comb begin
		clk_out_mode = (s_reg.w1[POS_EXT_MODE_HI:cwd_pkg::POS_EXT_MODE] inside
			{cwd_pkg::EXT_CLK_HIGH, cwd_pkg::EXT_CLK_MID, cwd_pkg::EXT_CLK_LOW,
			 cwd_pkg::EXT_OFF}) && !s_reg.w1[cwd_pkg::POS_CLK_OUT];
		one_way = s_reg.w2[cwd_pkg::POS_ONE_WAY];
		bor_on = 1'b0;
		pwrt_target = 20'h0_0000;
		zcd_on = s_reg.w2[cwd_pkg::POS_ZERO_CROSS] ? s_reg.zcd_sw : 1'b1;
		unique case (s_reg.w2[cwd_pkg::POS_BOR_FIELD+1:cwd_pkg::POS_BOR_FIELD])
			cwd_pkg::BOR_ALWAYS: bor_on = 1'b1;
			cwd_pkg::BOR_AWAKE:  bor_on = !sleep_in;
			cwd_pkg::BOR_SOFT:   bor_on = s_reg.bor_sw;
			cwd_pkg::BOR_OFF:    bor_on = 1'b0;
		endcase
		mclr_on = s_reg.w4[cwd_pkg::POS_LV_PROG] | s_reg.w2[cwd_pkg::POS_MCLR];
		unique case (s_reg.w2[cwd_pkg::POS_PWR_TIMER+1:cwd_pkg::POS_PWR_TIMER])
			cwd_pkg::PWRT_OFF: pwrt_target = 20'h0_0000;
			cwd_pkg::PWRT_64:  pwrt_target = 20'(PWRT_LONG_CYCLES);
			cwd_pkg::PWRT_16:  pwrt_target = 20'(PWRT_MID_CYCLES);
			cwd_pkg::PWRT_1:   pwrt_target = 20'(PWRT_SHORT_CYCLES);
		endcase
		// Status: lock, frozen, brown-out, zero-cross, clock-out, clear, timer
		status_word = {24'h00_0000, 1'b0, s_reg.pwrt_done, mclr_on,
			clk_out_mode, zcd_on, bor_on, s_reg.pin_frozen, s_reg.pin_lock};
	end

	// ==========================================================
	// Bus address phase
	// Reads answer from a register, so the slave never inserts waits
	always_comb begin
		addr_idx = haddr_in[17:2];
		addr_ok = (haddr_in[31:18] == 14'h0000) && (haddr_in[1:0] == 2'h0);
		take = hsel_in && hready_in && (htrans_in == cwd_pkg::HTRANS_NONSEQ);
		rst_code = cfg_word1_in[cwd_pkg::POS_RESET_OSC+2:cwd_pkg::POS_RESET_OSC];
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.wr_pend = 1'b0;
		s_next.switch_pend = 1'b0;
		s_next.div4 = s_reg.div4 + 2'h1;
		s_next.mclr_sync = {s_reg.mclr_sync[0], master_clear_pin_in};
		s_next.stack_rst = stack_fault_in && s_reg.w2[cwd_pkg::POS_STACK_RST];

		// One-shot capture after reset release, read-only afterward
		if (!s_reg.loaded) begin
			s_next.loaded = 1'b1;
			s_next.w1 = cfg_word1_in;
			s_next.w2 = cfg_word2_in;
			s_next.w3 = cfg_word3_in;
			s_next.w4 = cfg_word4_in;
			s_next.w5 = cfg_word5_in;
			s_next.cur_osc = rst_code;
			s_next.new_osc = rst_code;
			unique case (rst_code)
				cwd_pkg::RST_FAST_1MHZ: begin
					s_next.cur_frq = cwd_pkg::FRQ_4MHZ;
					s_next.cur_div = cwd_pkg::DIV_BY4;
				end
				cwd_pkg::RST_FAST_PLL2: begin
					s_next.cur_frq = cwd_pkg::FRQ_16MHZ;
					s_next.cur_div = cwd_pkg::DIV_BY1;
				end
				cwd_pkg::RST_FAST_32: begin
					s_next.cur_frq = cwd_pkg::FRQ_32MHZ;
					s_next.cur_div = cwd_pkg::DIV_BY1;
				end
				// External, PLL, slow, secondary and reserved codes keep defaults
				default: begin
					s_next.cur_frq = cwd_pkg::FRQ_4MHZ;
					s_next.cur_div = cwd_pkg::DIV_BY1;
				end
			endcase
			s_next.new_div = s_next.cur_div;
			s_next.pwrt_cnt = 20'h0_0000;
			s_next.pwrt_done = 1'b0;
		end else if (!s_reg.pwrt_done) begin
			if (s_reg.pwrt_cnt >= pwrt_target)
				s_next.pwrt_done = 1'b1;
			else
				s_next.pwrt_cnt = s_reg.pwrt_cnt + 20'h0_0001;
		end

		// Clock switch completes one cycle after the accepted write
		if (s_reg.switch_pend) begin
			s_next.cur_osc = s_reg.new_osc;
			s_next.cur_div = s_reg.new_div;
		end

		// Data phase of a write
		if (s_reg.wr_pend) begin
			unique case (s_reg.wr_idx)
				cwd_pkg::IDX_OSC_CTRL: begin
					if (s_reg.w1[cwd_pkg::POS_CLK_SWITCH]) begin
						s_next.new_osc = hwdata_in[6:4];
						s_next.new_div = hwdata_in[3:0];
						s_next.switch_pend = 1'b1;
					end
				end
				// Key 2 must follow key 1 with no other value written here in between; other values disarm
				cwd_pkg::IDX_UNLOCK: begin
					if (hwdata_in[7:0] == cwd_pkg::UNLOCK_KEY1)
						s_next.unlock_step = 2'h1;
					else if (hwdata_in[7:0] == cwd_pkg::UNLOCK_KEY2 &&
						s_reg.unlock_step == 2'h1)
						s_next.unlock_step = 2'h2;
					else
						s_next.unlock_step = 2'h0;
				end
				// Any lock write disarms; a set lock in one-way mode stays frozen
				cwd_pkg::IDX_PIN_LOCK: begin
					s_next.unlock_step = 2'h0;
					if (s_reg.unlock_step == 2'h2 && !s_reg.pin_frozen) begin
						s_next.pin_lock = hwdata_in[0];
						if (hwdata_in[0] && one_way)
							s_next.pin_frozen = 1'b1;
					end
				end
				cwd_pkg::IDX_SW_ENABLE: begin
					s_next.zcd_sw = hwdata_in[0];
					s_next.bor_sw = hwdata_in[1];
				end
				// Configuration words, status and unmapped writes are ignored
				default: begin
				end
			endcase
		end

		// Address phase: capture write target or fetch read data
		if (take && hwrite_in) begin
			s_next.wr_pend = addr_ok;
			s_next.wr_idx = addr_idx;
		end
		if (take && !hwrite_in) begin
			s_next.rdata = 32'h0000_0000;
			if (addr_ok) begin
				unique case (addr_idx)
					cwd_pkg::IDX_OSC_WORD:   s_next.rdata = {18'h0_0000, s_reg.w1};
					cwd_pkg::IDX_SUPV_WORD:  s_next.rdata = {18'h0_0000, s_reg.w2};
					cwd_pkg::IDX_WDOG_WORD:  s_next.rdata = {18'h0_0000, s_reg.w3};
					cwd_pkg::IDX_MPROT_WORD: s_next.rdata = {18'h0_0000, s_reg.w4};
					cwd_pkg::IDX_CPROT_WORD: s_next.rdata = {18'h0_0000, s_reg.w5};
					cwd_pkg::IDX_OSC_CTRL:
						s_next.rdata = {13'h0000, s_reg.cur_frq, s_reg.cur_div,
							1'b0, s_reg.cur_osc, 1'b0, s_reg.new_osc, s_reg.new_div};
					cwd_pkg::IDX_UNLOCK:
						s_next.rdata = {30'h0000_0000, s_reg.unlock_step};
					cwd_pkg::IDX_PIN_LOCK:
						s_next.rdata = {30'h0000_0000, s_reg.pin_frozen, s_reg.pin_lock};
					cwd_pkg::IDX_SW_ENABLE:
						s_next.rdata = {30'h0000_0000, s_reg.bor_sw, s_reg.zcd_sw};
					cwd_pkg::IDX_STATUS:     s_next.rdata = status_word;
					default:                 s_next.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Registers
	// Pin synchroniser resets high so no false clear follows reset
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '{
				w1: cwd_pkg::WORD_RESET, w2: cwd_pkg::WORD_RESET,
				w3: cwd_pkg::WORD_RESET, w4: cwd_pkg::WORD_RESET,
				w5: cwd_pkg::WORD_RESET,
				loaded: 1'b0,
				cur_osc: cwd_pkg::RST_EXT, cur_frq: cwd_pkg::FRQ_4MHZ,
				cur_div: cwd_pkg::DIV_BY1,
				new_osc: cwd_pkg::RST_EXT, new_div: cwd_pkg::DIV_BY1,
				switch_pend: 1'b0, unlock_step: 2'h0,
				pin_lock: 1'b0, pin_frozen: 1'b0,
				zcd_sw: 1'b0, bor_sw: 1'b0, div4: 2'h0,
				wr_pend: 1'b0, wr_idx: 16'h0000, rdata: 32'h0000_0000,
				pwrt_cnt: 20'h0_0000, pwrt_done: 1'b0,
				mclr_sync: 2'h3, stack_rst: 1'b0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		hrdata_out = s_reg.rdata;
		hreadyout_out = 1'b1;
		hresp_out = 1'b0;
		fail_safe_monitor_enable_out = s_reg.w1[cwd_pkg::POS_FAIL_SAFE];
		current_oscillator_select_out = s_reg.cur_osc;
		internal_frequency_select_out = s_reg.cur_frq;
		clock_divider_field_out = s_reg.cur_div;
		external_oscillator_mode_out = s_reg.w1[POS_EXT_MODE_HI:cwd_pkg::POS_EXT_MODE];
		// Bit 1 of the free counter gives the system clock over four
		second_oscillator_pin_out = clk_out_mode & s_reg.div4[1];
		second_oscillator_pin_oe_out = clk_out_mode;
		debugger_enable_out = !s_reg.w2[cwd_pkg::POS_DEBUGGER];
		stack_fault_reset_out = s_reg.stack_rst;
		pin_select_lock_flag_out = s_reg.pin_lock;
		zero_cross_enable_out = zcd_on;
		brownout_low_trip_out = s_reg.w2[cwd_pkg::POS_BOR_VOLT];
		brownout_enable_out = bor_on;
		low_power_brownout_enable_out = !s_reg.w2[cwd_pkg::POS_LP_BOR];
		power_up_done_out = s_reg.pwrt_done;
		master_clear_reset_out = mclr_on & !s_reg.mclr_sync[1];
		master_clear_port_mode_out = !mclr_on;
	end
endmodule : cwd_config_word_decode

/* File: src/cwd_pkg.sv */
// Constants for the configuration word decoder: word indices, field positions,
// codes and timing. Assumes a 10 MHz system clock.
package cwd_pkg;
	// ==========================================================
	// Word indices (byte address is four times the index)
	localparam logic [15:0] IDX_OSC_WORD   = 16'h8007;
	localparam logic [15:0] IDX_SUPV_WORD  = 16'h8008;
	localparam logic [15:0] IDX_WDOG_WORD  = 16'h8009;
	localparam logic [15:0] IDX_MPROT_WORD = 16'h800a;
	localparam logic [15:0] IDX_CPROT_WORD = 16'h800b;
	localparam logic [15:0] IDX_OSC_CTRL   = 16'h8010;
	localparam logic [15:0] IDX_UNLOCK     = 16'h8011;
	localparam logic [15:0] IDX_PIN_LOCK   = 16'h8012;
	localparam logic [15:0] IDX_SW_ENABLE  = 16'h8013;
	localparam logic [15:0] IDX_STATUS     = 16'h8014;
	localparam logic [13:0] WORD_RESET     = 14'h3fff;
	// ==========================================================
	// Field positions
	localparam int POS_FAIL_SAFE   = 13;
	localparam int POS_CLK_SWITCH  = 11;
	localparam int POS_CLK_OUT     = 8;
	localparam int POS_RESET_OSC   = 4;
	localparam int POS_EXT_MODE    = 0;
	localparam int POS_DEBUGGER    = 13;
	localparam int POS_STACK_RST   = 12;
	localparam int POS_ONE_WAY     = 11;
	localparam int POS_ZERO_CROSS  = 10;
	localparam int POS_BOR_VOLT    = 9;
	localparam int POS_BOR_FIELD   = 6;
	localparam int POS_LP_BOR      = 5;
	localparam int POS_PWR_TIMER   = 1;
	localparam int POS_MCLR        = 0;
	localparam int POS_LV_PROG     = 13;
	// ==========================================================
	// Reset oscillator, frequency and divider codes
	localparam logic [2:0] RST_EXT       = 3'h7;
	localparam logic [2:0] RST_FAST_1MHZ = 3'h6;
	localparam logic [2:0] RST_SLOW      = 3'h5;
	localparam logic [2:0] RST_SECONDARY = 3'h4;
	localparam logic [2:0] RST_RESERVED  = 3'h3;
	localparam logic [2:0] RST_EXT_PLL4  = 3'h2;
	localparam logic [2:0] RST_FAST_PLL2 = 3'h1;
	localparam logic [2:0] RST_FAST_32   = 3'h0;
	localparam logic [2:0] FRQ_4MHZ      = 3'h2;
	localparam logic [2:0] FRQ_16MHZ     = 3'h5;
	localparam logic [2:0] FRQ_32MHZ     = 3'h6;
	localparam logic [3:0] DIV_BY4       = 4'h2;
	localparam logic [3:0] DIV_BY1       = 4'h0;
	// ==========================================================
	// External oscillator modes
	localparam logic [2:0] EXT_CLK_HIGH  = 3'h7;
	localparam logic [2:0] EXT_CLK_MID   = 3'h6;
	localparam logic [2:0] EXT_CLK_LOW   = 3'h5;
	localparam logic [2:0] EXT_OFF       = 3'h4;
	localparam logic [2:0] EXT_RESERVED  = 3'h3;
	localparam logic [2:0] XTAL_HS       = 3'h2;
	localparam logic [2:0] XTAL_XT       = 3'h1;
	localparam logic [2:0] XTAL_LP       = 3'h0;
	// ==========================================================
	// Brown-out and power-up timer codes
	localparam logic [1:0] BOR_ALWAYS    = 2'h3;
	localparam logic [1:0] BOR_AWAKE     = 2'h2;
	localparam logic [1:0] BOR_SOFT      = 2'h1;
	localparam logic [1:0] BOR_OFF       = 2'h0;
	localparam logic [1:0] PWRT_OFF      = 2'h3;
	localparam logic [1:0] PWRT_64       = 2'h2;
	localparam logic [1:0] PWRT_16       = 2'h1;
	localparam logic [1:0] PWRT_1        = 2'h0;
	localparam int CLOCK_HZ      = 10_000_000;
	localparam int PWRT_LONG_MS  = 64;
	localparam int PWRT_MID_MS   = 16;
	localparam int PWRT_SHORT_MS = 1;
	// ==========================================================
	// Bus and unlock constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2   = 8'haa;
endpackage : cwd_pkg
